// file: verilog/pex_defines.vh
// Timing counts and field positions for the paged memory host controller
`ifndef PEX_DEFINES_VH
`define PEX_DEFINES_VH
// Pin-level timing in ns and the derived 100 MHz cycle counts
`define PEX_CLK_NS 10
`define PEX_WP_NS 100
`define PEX_WP_CYC ((`PEX_WP_NS + `PEX_CLK_NS - 1) / `PEX_CLK_NS)
`define PEX_WPH_NS 50
`define PEX_WPH_CYC ((`PEX_WPH_NS + `PEX_CLK_NS - 1) / `PEX_CLK_NS)
`define PEX_ACC_NS 150
`define PEX_ACC_CYC ((`PEX_ACC_NS + `PEX_CLK_NS - 1) / `PEX_CLK_NS)
`define PEX_OEHP_NS 150
`define PEX_OEHP_CYC ((`PEX_OEHP_NS + `PEX_CLK_NS - 1) / `PEX_CLK_NS)
// Byte load window, longest time, rounded down
`define PEX_BLW_US 150
`define PEX_BLW_CYC ((`PEX_BLW_US * 1000) / `PEX_CLK_NS)
// Longest write cycle in us, default variant
`define PEX_TWC_US 10000
`define PEX_TWC_CYC ((`PEX_TWC_US * 1000) / `PEX_CLK_NS)
// Page and id area layout
`define PEX_PAGE_LSB 6
`define PEX_PAGE_BYTES 64
`define PEX_ID_BASE 15'h7FC0
`define PEX_TOGGLE_BIT 6
`define PEX_POLL_BIT 7
// Command codes of the host port
`define PEX_CMD_READ 2'h0
`define PEX_CMD_LOAD 2'h1
`define PEX_CMD_POLL 2'h2
`endif

// file: verilog/pex_timer.v
// Cycle down-counter used for pulse widths and time-outs
module pex_timer #(
  parameter WIDTH = 20
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Control
  input wire load,
  input wire [WIDTH-1:0] value,
  // Status
  output wire done
);
  reg [WIDTH-1:0] count;

  // Load or count to zero
  always @(posedge CLK) begin
    if (SYS_RST) begin
      count <= {WIDTH{1'b0}};
    end else if (load) begin
      count <= value;
    end else if (count != {WIDTH{1'b0}}) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == {WIDTH{1'b0}}) && !load;
endmodule

// file: verilog/pex_host.v
// Host controller driving a paged byte-wide erasable memory over its pins
`include "pex_defines.vh"
module pex_host #(
  parameter TWC_CYC = `PEX_TWC_CYC,
  parameter BLW_CYC = `PEX_BLW_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // User command port
  input wire REQ_VALID,
  input wire [1:0] REQ_CMD,
  input wire [14:0] REQ_ADDR,
  input wire [7:0] REQ_DATA,
  input wire REQ_LAST,
  input wire REQ_ID,
  output reg REQ_READY,
  output reg RSP_VALID,
  output reg [7:0] RSP_DATA,
  output reg RSP_TIMEOUT,
  output reg PAGE_ERROR,
  // Memory pins
  output reg CHIP_SEL_N,
  output reg OUT_EN_N,
  output reg WR_STROBE_N,
  output reg [14:0] ADDR,
  output reg HIGH_VOLTAGE_SEL,
  output reg [7:0] DQ_OUT,
  output reg DQ_OE,
  input wire [7:0] DQ_IN
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_RECOVER = 3'h3;
  localparam ST_RDWAIT = 3'h4;
  localparam ST_GAP = 3'h5;
  localparam ST_PAGE = 3'h6;
  localparam TW = 24;
  // Timer loads, cut to the timer width where used
  localparam integer ACC_VAL = `PEX_ACC_CYC;
  localparam integer WP_VAL = `PEX_WP_CYC;
  localparam integer WPH_VAL = `PEX_WPH_CYC;
  localparam integer OEHP_VAL = `PEX_OEHP_CYC;

  reg [2:0] state;
  reg [1:0] cmd;
  reg in_page;
  reg last;
  reg poll_seen;
  reg [7:0] poll_prev;
  reg [7:0] dq_meta;
  reg [7:0] dq_sync;
  reg [8:0] page_addr;
  reg tmr_load;
  reg [TW-1:0] tmr_val;
  reg blw_load;
  reg twc_load;
  wire tmr_done;
  wire blw_done;
  wire twc_done;

  // Pulse width and recovery timer
  pex_timer #(.WIDTH(TW)) u_pulse (
    .CLK(CLK), .SYS_RST(SYS_RST), .load(tmr_load), .value(tmr_val), .done(tmr_done)
  );
  // Byte load window timer
  pex_timer #(.WIDTH(TW)) u_window (
    .CLK(CLK), .SYS_RST(SYS_RST), .load(blw_load), .value(BLW_CYC[TW-1:0]),
    .done(blw_done)
  );
  // Longest write cycle timer
  pex_timer #(.WIDTH(TW)) u_wcycle (
    .CLK(CLK), .SYS_RST(SYS_RST), .load(twc_load), .value(TWC_CYC[TW-1:0]),
    .done(twc_done)
  );

  // Two-stage synchroniser on the data pins
  always @(posedge CLK) begin
    dq_meta <= DQ_IN;
    dq_sync <= dq_meta;
  end

  // Main sequencer
  always @(posedge CLK) begin
    tmr_load <= 1'b0;
    tmr_val <= {TW{1'b0}};
    blw_load <= 1'b0;
    twc_load <= 1'b0;
    RSP_VALID <= 1'b0;
    if (SYS_RST) begin
      state <= ST_IDLE;
      cmd <= `PEX_CMD_READ;
      in_page <= 1'b0;
      last <= 1'b0;
      poll_seen <= 1'b0;
      poll_prev <= 8'h00;
      page_addr <= 9'h000;
      REQ_READY <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_TIMEOUT <= 1'b0;
      PAGE_ERROR <= 1'b0;
      CHIP_SEL_N <= 1'b1;
      OUT_EN_N <= 1'b1;
      WR_STROBE_N <= 1'b1;
      ADDR <= 15'h0000;
      HIGH_VOLTAGE_SEL <= 1'b0;
      DQ_OUT <= 8'h00;
      DQ_OE <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            cmd <= REQ_CMD;
            last <= REQ_LAST;
            PAGE_ERROR <= 1'b0;
            RSP_TIMEOUT <= 1'b0;
            HIGH_VOLTAGE_SEL <= REQ_ID;
            ADDR <= REQ_ID ? (`PEX_ID_BASE | REQ_ADDR) : REQ_ADDR;
            // erase code bytes go out as plain loads
            if (REQ_CMD == `PEX_CMD_LOAD) begin
              // page address fixed for whole load
              if (in_page && REQ_ADDR[14:`PEX_PAGE_LSB] != page_addr) begin
                PAGE_ERROR <= 1'b1;
                state <= ST_GAP;
              end else begin
                page_addr <= REQ_ADDR[14:`PEX_PAGE_LSB];
                DQ_OUT <= REQ_DATA;
                DQ_OE <= 1'b1;
                // output enable high before the strobe
                OUT_EN_N <= 1'b1;
                CHIP_SEL_N <= 1'b0;
                state <= ST_SETUP;
              end
            end else begin
              // read with strobe high, select and output enable low
              DQ_OE <= 1'b0;
              CHIP_SEL_N <= 1'b0;
              OUT_EN_N <= 1'b0;
              tmr_load <= 1'b1;
              tmr_val <= ACC_VAL[TW-1:0];
              // A user poll gets its own longest write time
              twc_load <= (REQ_CMD == `PEX_CMD_POLL);
              poll_seen <= 1'b0;
              state <= ST_RDWAIT;
            end
          end else if (in_page && blw_done) begin
            in_page <= 1'b0;
            poll_seen <= 1'b0;
            twc_load <= 1'b1;
            REQ_READY <= 1'b0;
            state <= ST_PAGE;
          end
        end
        ST_SETUP: begin
          // strobe falls with output enable already high
          WR_STROBE_N <= 1'b0;
          tmr_load <= 1'b1;
          tmr_val <= WP_VAL[TW-1:0];
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          if (tmr_done) begin
            WR_STROBE_N <= 1'b1;
            CHIP_SEL_N <= 1'b1;
            tmr_load <= 1'b1;
            tmr_val <= WPH_VAL[TW-1:0];
            // byte load window runs from the strobe rise
            blw_load <= 1'b1;
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (tmr_done) begin
            DQ_OE <= 1'b0;
            RSP_VALID <= 1'b1;
            // keep page between bytes after a code
            // user closes the load with its last byte
            if (last) begin
              in_page <= 1'b0;
              twc_load <= 1'b1;
              poll_seen <= 1'b0;
              state <= ST_PAGE;
            end else begin
              // page stays open while the window runs
              in_page <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        ST_PAGE: begin
          // wait for toggle to stop or longest write time
          // output enable high pulse before each poll read
          if (tmr_done) begin
            if (twc_done) begin
              RSP_TIMEOUT <= 1'b1;
              HIGH_VOLTAGE_SEL <= 1'b0;
              poll_seen <= 1'b0;
              state <= ST_IDLE;
            end else begin
              CHIP_SEL_N <= 1'b0;
              OUT_EN_N <= 1'b0;
              tmr_load <= 1'b1;
              tmr_val <= ACC_VAL[TW-1:0];
              cmd <= `PEX_CMD_POLL;
              state <= ST_RDWAIT;
            end
          end
        end
        ST_RDWAIT: begin
          if (tmr_done) begin
            CHIP_SEL_N <= 1'b1;
            OUT_EN_N <= 1'b1;
            tmr_load <= 1'b1;
            tmr_val <= OEHP_VAL[TW-1:0];
            if (cmd == `PEX_CMD_POLL) begin
              poll_prev <= dq_sync;
              poll_seen <= 1'b1;
              // data read after completion is true data
              if (poll_seen &&
                  dq_sync[`PEX_TOGGLE_BIT] == poll_prev[`PEX_TOGGLE_BIT]) begin
                RSP_DATA <= dq_sync;
                RSP_VALID <= 1'b1;
                poll_seen <= 1'b0;
                state <= ST_GAP;
              end else begin
                state <= ST_PAGE;
              end
            end else begin
              RSP_DATA <= dq_sync;
              RSP_VALID <= 1'b1;
              state <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // Output enable high pulse between accesses
          if (tmr_done) begin
            if (!in_page) begin
              HIGH_VOLTAGE_SEL <= 1'b0;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: sim/pex_host_monitor.sv
// Pin and handshake checker for the paged memory host controller
module pex_host_monitor (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Watched ports
  input wire REQ_READY,
  input wire CHIP_SEL_N,
  input wire OUT_EN_N,
  input wire WR_STROBE_N,
  input wire [14:0] ADDR,
  input wire HIGH_VOLTAGE_SEL,
  input wire DQ_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Strobe fall and a qualified low pulse after it
  sequence s_wr_fall;
    $fell(WR_STROBE_N);
  endsequence
  sequence s_wr_pulse;
    (!WR_STROBE_N && !CHIP_SEL_N && OUT_EN_N && DQ_OE) [*8];
  endsequence
  a_wr_pulse_ok: assert property (s_wr_fall |-> s_wr_pulse)
    else $error("write pulse short or badly qualified");
  a_read_no_drive: assert property (!OUT_EN_N |-> WR_STROBE_N && !DQ_OE)
    else $error("host drives or strobes during a read");
  a_addr_held: assert property (!WR_STROBE_N && !$past(WR_STROBE_N) |-> $stable(ADDR))
    else $error("address moved inside a write pulse");
  a_id_page: assert property (HIGH_VOLTAGE_SEL && !CHIP_SEL_N |-> ADDR[14:6] == 9'h1FF)
    else $error("id access outside the top page");
  a_reset_idle: assert property ($fell(SYS_RST) |-> CHIP_SEL_N && WR_STROBE_N && !DQ_OE
    && !REQ_READY)
    else $error("pins not idle after reset");
  a_busy_refuse: assert property (!CHIP_SEL_N |-> !REQ_READY)
    else $error("request accepted during a bus cycle");
  a_read_hold: assert property ($fell(OUT_EN_N) |-> (!OUT_EN_N && !CHIP_SEL_N) [*8])
    else $error("read strobe too short");
  a_oe_gap: assert property ($rose(OUT_EN_N) |-> OUT_EN_N [*8])
    else $error("output enable high gap too short");
endmodule

// file: sim/pex_mem_model.sv
// Behavioural paged memory device seen from the host pins
module pex_mem_model #(
  parameter BLW_NS = 3100,
  parameter TWC_NS = 5000
) (
  // Memory pins
  input wire CHIP_SEL_N,
  input wire OUT_EN_N,
  input wire WR_STROBE_N,
  input wire [14:0] ADDR,
  input wire HIGH_VOLTAGE_SEL,
  input wire [7:0] DQ_OUT,
  input wire DQ_OE,
  output wire [7:0] DQ_IN,
  // Host fault count
  output int bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:32767];
  logic [7:0] idm [0:63];
  logic [7:0] q = 8'h00;
  logic [8:0] pg = 9'h000;
  logic busy = 1'b0;
  logic tgl = 1'b0;
  time lt = 0;
  logic armed = 1'b0;
  wire idsel = HIGH_VOLTAGE_SEL && ADDR[14:6] == 9'h1FF;
  // Drive on read, else the host data while DQ_OE is set, else the inverse of the last value
  assign DQ_IN = (!CHIP_SEL_N && !OUT_EN_N && WR_STROBE_N) ? q : (DQ_OE ? DQ_OUT : ~q);
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (idm[i]) idm[i] = 8'hFF;
    bad = 0;
  end
  // Write pulse armed at strobe fall with select low
  always @(negedge WR_STROBE_N) armed = !CHIP_SEL_N;
  // Byte taken at pulse end, host faults counted
  always @(posedge WR_STROBE_N or posedge CHIP_SEL_N) if (armed) begin
    armed = 1'b0;
    if (!OUT_EN_N || !DQ_OE) bad++;
    if (busy && ($time - lt > BLW_NS || ADDR[14:6] != pg)) bad++;
    if (OUT_EN_N && idsel) idm[ADDR[5:0]] = DQ_OUT;
    else if (OUT_EN_N) mem[ADDR] = DQ_OUT;
    pg = ADDR[14:6];
    lt = $time;
    busy = 1'b1;
  end
  // Programming ends BLW_NS plus TWC_NS after the last byte
  always #10 if (busy && $time - lt > BLW_NS + TWC_NS) busy = 1'b0;
  // Busy reads invert the top bit and toggle bit six
  always @(negedge OUT_EN_N) begin
    #1;
    if (!CHIP_SEL_N && WR_STROBE_N) begin
      q = idsel ? idm[ADDR[5:0]] : mem[ADDR];
      tgl = ~tgl;
      if (busy) q = {~q[7], tgl, q[5:0]};
    end
  end
endmodule

// file: sim/pex_host_tb.sv
// Self-checking bench for the paged memory host controller
module pex_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  logic CLK = 0, SYS_RST = 1, REQ_VALID = 0, REQ_LAST = 0, REQ_ID = 0;
  logic [1:0] REQ_CMD = 2'h0;
  logic [14:0] REQ_ADDR = 15'h0000, pa;
  logic [7:0] REQ_DATA = 8'h00;
  wire REQ_READY, RSP_VALID, RSP_TIMEOUT, PAGE_ERROR, CHIP_SEL_N, OUT_EN_N, WR_STROBE_N;
  wire HIGH_VOLTAGE_SEL, DQ_OE;
  wire [14:0] ADDR;
  wire [7:0] RSP_DATA, DQ_OUT, DQ_IN;
  int error_cnt = 0, num_checks = 0, seed = 32'h2dd1, bad, n;
  logic [7:0] rm [int];
  pex_host #(.TWC_CYC(2000), .BLW_CYC(300)) uut (.CLK, .SYS_RST, .REQ_VALID, .REQ_CMD,
    .REQ_ADDR, .REQ_DATA, .REQ_LAST, .REQ_ID, .REQ_READY, .RSP_VALID, .RSP_DATA,
    .RSP_TIMEOUT, .PAGE_ERROR, .CHIP_SEL_N, .OUT_EN_N, .WR_STROBE_N, .ADDR,
    .HIGH_VOLTAGE_SEL, .DQ_OUT, .DQ_OE, .DQ_IN);
  pex_mem_model dev (.CHIP_SEL_N, .OUT_EN_N, .WR_STROBE_N, .ADDR, .HIGH_VOLTAGE_SEL,
    .DQ_OUT, .DQ_OE, .DQ_IN, .bad);
  initial forever #5 CLK = ~CLK;
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait for the ready level
  task automatic wait_rdy();
    n = 0;
    while (REQ_READY !== 1'b1) begin
      @(negedge CLK);
      if (++n > 9000) begin
        error_cnt++;
        conclude();
      end
    end
  endtask
  // One request, optionally waiting for its answer pulse
  task automatic op(input logic [1:0] c, input logic [14:0] a, input logic [7:0] d,
    input logic l, input logic i, input bit w);
    REQ_CMD = c;
    REQ_ADDR = a;
    REQ_DATA = d;
    REQ_LAST = l;
    REQ_ID = i;
    REQ_VALID = 1;
    wait_rdy();
    @(negedge CLK);
    REQ_VALID = 0;
    n = 0;
    while (w && RSP_VALID !== 1'b1) begin
      @(negedge CLK);
      if (++n > 9000) begin
        error_cnt++;
        conclude();
      end
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic l, input logic i);
    op(2'h1, a, d, l, i, 1);
    rm[{i, a}] = d;
  endtask
  task automatic rd_chk(input logic [1:0] c, input logic [14:0] a, input logic i);
    op(c, a, 8'h00, 0, i, 1);
    `CHK(RSP_DATA, rm.exists({i, a}) ? rm[{i, a}] : 8'hFF)
  endtask
  initial begin
    repeat (4) @(negedge CLK);
    SYS_RST = 0;
    pa = 15'($random(seed)) & 15'h7FC0;
    for (int k = 0; k < 64; k++) wr(pa | 15'(k), 8'($random(seed)), k == 63, 0);
    for (int k = 0; k < 64; k += 9) rd_chk(k[0] ? 2'h2 : 2'h0, pa | 15'(k), 0);
    $display("test full page done");
    wr(15'h7FC5, 8'($random(seed)), 1, 1);
    rd_chk(2'h0, 15'h7FC5, 1);
    rd_chk(2'h0, 15'h7FC5, 0);
    $display("test id area done");
    wr(15'h0100, 8'h11, 0, 0);
    op(2'h1, 15'h0200, 8'h22, 0, 0, 0);
    wait_rdy();
    `CHK(PAGE_ERROR, 1'b1)
    wr(15'h0101, 8'h33, 1, 0);
    `CHK(PAGE_ERROR, 1'b0)
    rd_chk(2'h0, 15'h0200, 0);
    rd_chk(2'h2, 15'h0101, 0);
    $display("test page refuse done");
    wr(15'h1230, 8'hA5, 0, 0);
    wr(15'h1231, 8'($random(seed)), 0, 0);
    repeat (350) @(negedge CLK);
    rd_chk(2'h2, 15'h1231, 0);
    rd_chk(2'h0, 15'h1230, 0);
    `CHK(RSP_TIMEOUT, 1'b0)
    `CHK(bad, 0)
    $display("test window close done");
    conclude();
  end
endmodule
bind pex_host pex_host_monitor mon (.CLK, .SYS_RST, .REQ_READY, .CHIP_SEL_N, .OUT_EN_N,
  .WR_STROBE_N, .ADDR, .HIGH_VOLTAGE_SEL, .DQ_OE);
